// ===== owsl_slave.sv
// slave end: reset detect, presence pulse, write sample, read drive
`timescale 1ns/10ps
`include "owsl_map.svh"
module owsl_slave
  import owsl_pkg::*;
#(
  // cycles per microsecond; every count below scales from it
  parameter int US_CYC = `OWSL_CYC(1),
  parameter int RST_DET_CYC = US_CYC * `OWSL_RST_DET_US,
  parameter int PRES_WAIT_CYC = US_CYC * `OWSL_PRES_WAIT_US,
  parameter int PRES_LOW_CYC = US_CYC * `OWSL_PRES_LOW_US,
  parameter int SAMPLE_CYC = US_CYC * `OWSL_SAMPLE_US,
  parameter int RD_HOLD_CYC = US_CYC * `OWSL_RD_HOLD_US
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  owsl_if.slave bus,
  output logic init_done_o,
  output logic rx_valid_o,
  output logic rx_bit_o,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic tx_bit_i,
  output logic tx_ready_o,
  input wire logic rd_slot_i
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // one state per phase of the init sequence or of a slot
  typedef enum logic [2:0] {
    S_IDLE, S_RST_LOW, S_PRES_WAIT, S_PRES_LOW, S_SLOT, S_WAIT_HIGH
  } owsl_sst_e;

  // cnt times the phases, low_q measures any low on its own
  owsl_sst_e st_q, st_d;
  owsl_cnt_t cnt_q, cnt_d;
  owsl_cnt_t low_q, low_d;
  logic line_q, line_d;
  logic oe_n_q, oe_n_d;
  logic init_q, init_d;
  logic rxv_q, rxv_d;
  logic rxb_q, rxb_d;
  logic txr_q, txr_d;
  logic txb_q, txb_d;
  logic txh_q, txh_d;
  logic fall;

  // line_q resets high, the idle level, so no false edge follows reset
  assign fall = line_q & ~bus.line;

  // ------------------------------------------------------------
  // slot sequencer
  // ------------------------------------------------------------
  // next state: low-pulse measure dominates every activity but the presence low
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 20'h00001;
    low_d = bus.line ? 20'h00000 : low_q + 20'h00001;
    line_d = bus.line;
    oe_n_d = oe_n_q;
    init_d = init_q;
    rxv_d = rxv_q & ~rx_ready_i;
    rxb_d = rxb_q;
    txr_d = txr_q;
    txb_d = txb_q;
    txh_d = txh_q;
    // a loaded bit waits in txb_q until the next read slot
    if (tx_valid_i && txr_q) begin
      txb_d = tx_bit_i;
      txh_d = 1'b1;
      txr_d = 1'b0;
    end
    // our own presence low must never count as a master reset
    if (!bus.line && low_q >= owsl_cnt_t'(RST_DET_CYC) &&
        st_q != S_PRES_LOW) begin
      st_d = S_RST_LOW;
      oe_n_d = 1'b1;
      init_d = 1'b0;
      rxv_d = 1'b0;
      txh_d = 1'b0;
      txr_d = 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (fall) begin
            // a reset pulse first looks like a write-zero slot;
            // the stray bit is dropped once the low hits the threshold
            cnt_d = 20'h00000;
            st_d = S_SLOT;
            if (rd_slot_i && init_q && txh_q && !txb_q) begin
              oe_n_d = 1'b0;
            end
          end
        end
        S_RST_LOW: begin
          if (bus.line) begin
            cnt_d = 20'h00000;
            st_d = S_PRES_WAIT;
          end
        end
        S_PRES_WAIT: begin
          // wait runs from the rise after the master's reset low
          if (cnt_q >= owsl_cnt_t'(PRES_WAIT_CYC)) begin
            cnt_d = 20'h00000;
            oe_n_d = 1'b0;
            st_d = S_PRES_LOW;
          end
        end
        S_PRES_LOW: begin
          if (cnt_q >= owsl_cnt_t'(PRES_LOW_CYC)) begin
            oe_n_d = 1'b1;
            init_d = 1'b1;
            txr_d = 1'b1;
            st_d = S_WAIT_HIGH;
          end
        end
        S_SLOT: begin
          if (rd_slot_i) begin
            if (cnt_q >= owsl_cnt_t'(RD_HOLD_CYC)) begin
              // released even for a one, so the next bit may load
              oe_n_d = 1'b1;
              if (txh_q) begin
                txh_d = 1'b0;
                txr_d = 1'b1;
              end
              st_d = S_WAIT_HIGH;
            end
          end else if (cnt_q >= owsl_cnt_t'(SAMPLE_CYC)) begin
            rxb_d = bus.line;
            rxv_d = init_q;
            st_d = S_WAIT_HIGH;
          end
        end
        S_WAIT_HIGH: begin
          if (bus.line) begin
            // no new slot until the line is back high
            st_d = S_IDLE;
          end
        end
        default: st_d = S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // registers only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      cnt_q <= 20'h00000;
      low_q <= 20'h00000;
      line_q <= 1'b1;
      oe_n_q <= 1'b1;
      init_q <= 1'b0;
      rxv_q <= 1'b0;
      rxb_q <= 1'b0;
      txr_q <= 1'b0;
      txb_q <= 1'b0;
      txh_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      line_q <= line_d;
      oe_n_q <= oe_n_d;
      init_q <= init_d;
      rxv_q <= rxv_d;
      rxb_q <= rxb_d;
      txr_q <= txr_d;
      txb_q <= txb_d;
      txh_q <= txh_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a flop with no gating after it
  assign bus.slv_oe_n = oe_n_q;
  assign init_done_o = init_q;
  assign rx_valid_o = rxv_q;
  assign rx_bit_o = rxb_q;
  assign tx_ready_o = txr_q;
endmodule : owsl_slave

// ===== owsl_map.svh
// timing constants of the single-wire link, both ends
`ifndef OWSL_MAP_SVH
`define OWSL_MAP_SVH
// ------------------------------------------------------------
// clock and durations in microseconds
// ------------------------------------------------------------
`define OWSL_CLK_MHZ 100
`define OWSL_RESET_LOW_US 480
`define OWSL_RESET_HIGH_US 480
`define OWSL_PRES_WAIT_US 30
`define OWSL_PRES_LOW_US 120
`define OWSL_SLOT_US 80
`define OWSL_W1_LOW_US 6
`define OWSL_W0_LOW_US 70
`define OWSL_RD_LOW_US 2
`define OWSL_SAMPLE_US 30
`define OWSL_RD_HOLD_US 15
`define OWSL_M_SAMPLE_US 10
`define OWSL_REC_US 5
// slave samples reset at this low length (below the 480 the master gives)
`define OWSL_RST_DET_US 400
// ------------------------------------------------------------
// derived cycle counts
// ------------------------------------------------------------
`define OWSL_CYC(us) ((us) * `OWSL_CLK_MHZ)
`define OWSL_CNT_W 20
`endif

// ===== owsl_pkg.sv
// shared types of the single-wire link
package owsl_pkg;
  typedef logic [19:0] owsl_cnt_t;
  typedef enum logic [1:0] {
    OWSL_OP_RESET,
    OWSL_OP_WRITE,
    OWSL_OP_READ
  } owsl_op_e;
endpackage : owsl_pkg

// ===== owsl_if.sv
// open-drain line between the master and slave ends
`timescale 1ns/10ps
interface owsl_if;
  logic line;
  logic mst_oe_n;
  logic slv_oe_n;
  // wired-and with pull-up: low when any end enables its driver
  assign line = ~((~mst_oe_n) | (~slv_oe_n));
  modport master (input line, output mst_oe_n);
  modport slave (input line, output slv_oe_n);
endinterface : owsl_if

// ===== owsl_master.sv
// master end: issues reset, write and read slots on command
`timescale 1ns/10ps
`include "owsl_map.svh"
module owsl_master
  import owsl_pkg::*;
#(
  // cycles per microsecond; every count below scales from it
  parameter int US_CYC = `OWSL_CYC(1),
  parameter int RST_LOW_CYC = US_CYC * `OWSL_RESET_LOW_US,
  parameter int RST_HIGH_CYC = US_CYC * `OWSL_RESET_HIGH_US,
  parameter int SLOT_CYC = US_CYC * `OWSL_SLOT_US,
  parameter int W1_CYC = US_CYC * `OWSL_W1_LOW_US,
  parameter int W0_CYC = US_CYC * `OWSL_W0_LOW_US,
  parameter int RD_CYC = US_CYC * `OWSL_RD_LOW_US,
  parameter int MS_CYC = US_CYC * `OWSL_M_SAMPLE_US,
  parameter int REC_CYC = US_CYC * `OWSL_REC_US
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  owsl_if.master bus,
  input wire logic cmd_valid_i,
  input wire owsl_op_e cmd_op_i,
  input wire logic cmd_bit_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic rsp_bit_o
);
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH} owsl_mst_e;

  owsl_mst_e st_q, st_d;
  owsl_cnt_t cnt_q, cnt_d;
  owsl_cnt_t lowc_q, lowc_d;
  owsl_cnt_t endc_q, endc_d;
  logic rd_q, rd_d;
  logic oe_n_q, oe_n_d;
  logic done_q, done_d;
  logic rsp_q, rsp_d;
  logic rdy_q, rdy_d;

  // end count holds slot plus recovery (reset: low plus high time) so back-to-back slots are legal
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 20'h00001;
    lowc_d = lowc_q;
    endc_d = endc_q;
    rd_d = rd_q;
    oe_n_d = oe_n_q;
    done_d = 1'b0;
    rsp_d = rsp_q;
    case (st_q)
      M_IDLE: begin
        if (cmd_valid_i) begin
          cnt_d = 20'h00000;
          oe_n_d = 1'b0;
          st_d = M_LOW;
          rd_d = (cmd_op_i == OWSL_OP_READ);
          case (cmd_op_i)
            OWSL_OP_RESET: begin
              lowc_d = owsl_cnt_t'(RST_LOW_CYC);
              endc_d = owsl_cnt_t'(RST_LOW_CYC + RST_HIGH_CYC);
            end
            OWSL_OP_READ: begin
              lowc_d = owsl_cnt_t'(RD_CYC);
              endc_d = owsl_cnt_t'(SLOT_CYC + REC_CYC);
            end
            default: begin
              lowc_d = cmd_bit_i ? owsl_cnt_t'(W1_CYC) :
                                   owsl_cnt_t'(W0_CYC);
              endc_d = owsl_cnt_t'(SLOT_CYC + REC_CYC);
            end
          endcase
        end
      end
      M_LOW: begin
        if (cnt_q >= lowc_q - 20'h00001) begin
          oe_n_d = 1'b1;
          st_d = M_HIGH;
        end
      end
      M_HIGH: begin
        if (rd_q && cnt_q == owsl_cnt_t'(MS_CYC)) begin
          // sample inside the valid window
          rsp_d = bus.line;
        end
        if (cnt_q >= endc_q - 20'h00001) begin
          done_d = 1'b1;
          st_d = M_IDLE;
        end
      end
      default: st_d = M_IDLE;
    endcase
    // ready registered so the output comes straight from a flop
    rdy_d = (st_d == M_IDLE);
  end

  // registers only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= M_IDLE;
      cnt_q <= 20'h00000;
      lowc_q <= 20'h00000;
      endc_q <= 20'h00000;
      rd_q <= 1'b0;
      oe_n_q <= 1'b1;
      done_q <= 1'b0;
      rsp_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lowc_q <= lowc_d;
      endc_q <= endc_d;
      rd_q <= rd_d;
      oe_n_q <= oe_n_d;
      done_q <= done_d;
      rsp_q <= rsp_d;
      rdy_q <= rdy_d;
    end
  end

  assign bus.mst_oe_n = oe_n_q;
  assign cmd_ready_o = rdy_q;
  assign done_o = done_q;
  assign rsp_bit_o = rsp_q;
endmodule : owsl_master

// ===== owsl_link_properties.sv
// link checker: wire timing between the two ends
`timescale 1ns/10ps
module owsl_link_properties (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic line,
  input wire logic mst_oe_n,
  input wire logic slv_oe_n
);
  logic [11:0] lo_q, lo_d, hi_q, hi_d, sl_q, sl_d, ml_q, ml_d;
  logic pr_q, pr_d;
  logic [11:0] mg_q, mg_d;
  logic rl_q, rl_d;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // --------
  // run lengths
  // --------
  always_comb begin
    lo_d = line ? 12'h000 : lo_q + 12'h001;
    hi_d = line ? hi_q + 12'h001 : 12'h000;
    sl_d = slv_oe_n ? 12'h000 : sl_q + 12'h001;
    ml_d = mst_oe_n ? 12'h000 : ml_q + 12'h001;
    pr_d = slv_oe_n ? line : pr_q; // high start marks a presence pulse
    // cycles since the master's last falling edge, saturating
    mg_d = (!mst_oe_n && ml_q == 12'h000) ? 12'h001 :
      ((mg_q == 12'hfff) ? mg_q : mg_q + 12'h001);
    // last master low was a reset pulse
    rl_d = (mst_oe_n && ml_q != 12'h000) ? (ml_q >= 12'h1e0) : rl_q;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {lo_q, hi_q, sl_q, ml_q, pr_q} <= '0;
    end else begin
      {lo_q, hi_q, sl_q, ml_q, pr_q} <= {lo_d, hi_d, sl_d, ml_d, pr_d};
    end
  end
  // spacing counter starts saturated so the first pulse passes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mg_q <= 12'hfff;
      rl_q <= 1'b0;
    end else begin
      mg_q <= mg_d;
      rl_q <= rl_d;
    end
  end
  // --------
  // wire rules, one tick is one microsecond in the bench
  // --------
  a_pres_wait: assert property ($fell(slv_oe_n) && $past(line) |->
    hi_q >= 12'h00f && hi_q <= 12'h03c) else $error("presence wait");
  a_pres_len: assert property ($rose(slv_oe_n) && pr_q |->
    sl_q >= 12'h03c && sl_q <= 12'h0f0) else $error("presence length");
  a_pres_due: assert property ($rose(line) && lo_q >= 12'h1df |->
    ##[15:70] !slv_oe_n) else $error("no presence");
  a_read_hold: assert property ($rose(slv_oe_n) && !pr_q |->
    sl_q >= 12'h00d && sl_q <= 12'h03c) else $error("read hold");
  a_read_prompt: assert property ($fell(slv_oe_n) && !$past(line) |->
    $past(lo_q) <= 12'h003) else $error("read data late");
  a_quiet_idle: assert property (hi_q >= 12'h03d |-> slv_oe_n)
    else $error("slave drives idle line");
  a_mst_low_len: assert property (
    $rose(mst_oe_n) |-> ml_q inside
    {[12'h001:12'h00f], [12'h03c:12'h078], [12'h1e0:12'h3bf]})
    else $error("master low length");
  a_idle_reset: assert property (
    $past(rst_i) |-> mst_oe_n && slv_oe_n)
    else $error("line not idle after reset");
  a_slot_space: assert property ($fell(mst_oe_n) && !rl_q |->
    mg_q >= 12'h03d) else $error("slot too short");
  a_first_slot: assert property ($fell(mst_oe_n) && rl_q |->
    mg_q >= 12'h3c0) else $error("slot too soon after reset");
endmodule : owsl_link_properties

// ===== one_wire_slave_signaling_bench.sv
// bench: master and slave ends joined, driven from their user sides
`timescale 1ns/10ps
module one_wire_slave_signaling_bench;
  import owsl_pkg::*;
  logic core_clk_i, rst_i, c_val, c_bit, c_rdy, done, rsp;
  logic init, rx_v, rx_b, rx_r, tx_v, tx_b, tx_r, rd;
  owsl_op_e c_op;
  logic [3:0] pat = 4'h6;
  int n_fail, checked, cyc;
  owsl_if bus_if();
  // scaled so one microsecond is one cycle
  owsl_master #(.US_CYC(1))
  owsl_master_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus(bus_if),
    .cmd_valid_i(c_val), .cmd_op_i(c_op), .cmd_bit_i(c_bit),
    .cmd_ready_o(c_rdy), .done_o(done), .rsp_bit_o(rsp));
  owsl_slave #(.US_CYC(1))
  owsl_slave_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus(bus_if),
    .init_done_o(init), .rx_valid_o(rx_v), .rx_bit_o(rx_b),
    .rx_ready_i(rx_r), .tx_valid_i(tx_v), .tx_bit_i(tx_b),
    .tx_ready_o(tx_r), .rd_slot_i(rd));
  owsl_link_properties owsl_link_properties_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .line(bus_if.line), .mst_oe_n(bus_if.mst_oe_n),
    .slv_oe_n(bus_if.slv_oe_n));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // --------
  // tasks
  // --------
  task automatic chk(input string what, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk
  // bounded waits on done and tx_r: a stuck slot ends as a mismatch, not a hang
  task automatic do_op(input owsl_op_e op, input logic b);
    int k;
    k = 0;
    c_op <= op;
    c_bit <= b;
    c_val <= 1'b1;
    @(posedge core_clk_i);
    while (c_rdy !== 1'b1) @(posedge core_clk_i);
    c_val <= 1'b0;
    while (done !== 1'b1 && k < 2000) begin
      @(posedge core_clk_i);
      k++;
    end
    chk("done", done, 1'b1);
  endtask : do_op
  task automatic load_tx(input logic b);
    int k;
    k = 0;
    while (tx_r !== 1'b1 && k < 200) begin
      @(posedge core_clk_i);
      k++;
    end
    tx_v <= 1'b1;
    tx_b <= b;
    @(posedge core_clk_i);
    tx_v <= 1'b0;
  endtask : load_tx
  task automatic print_verdict;
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  // --------
  // main sequence: second pass resets mid-run after traffic
  // --------
  initial begin
    {rst_i, c_val, c_bit, rx_r, tx_v, tx_b, rd} <= 7'h40;
    c_op <= OWSL_OP_RESET;
    {n_fail, checked, cyc} = '0;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      do_op(OWSL_OP_RESET, 1'b0);
      chk("init_done", init, 1'b1);
      chk("tx_ready", tx_r, 1'b1);
      for (int i = 0; i < 4; i++) begin
        do_op(OWSL_OP_WRITE, pat[i]);
        chk("rx_valid", rx_v, 1'b1);
        chk("rx_bit", rx_b, pat[i]);
        rx_r <= 1'b1;
        @(posedge core_clk_i);
        rx_r <= 1'b0;
      end
      // read-slot flag held steady across all three read slots
      rd <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        if (i < 2) load_tx(pat[i]);
        do_op(OWSL_OP_READ, 1'b1);
        chk("rsp_bit", rsp, (i < 2) ? pat[i] : 1'b1);
      end
      rd <= 1'b0;
    end
    print_verdict();
  end
endmodule : one_wire_slave_signaling_bench
